// file: sltc_pkg.sv
// Purpose: constants and carriers for the serial link transmit configuration bank
// Assumes: byte-wide registers behind the configuration serial port write/read strobes
// Notes:   offsets and fields are the hardware map
package sltc_pkg;

  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  ADDR_LANE_DRV    = 8'h47;
  localparam logic [7:0]  ADDR_LINK_CFG    = 8'h60;
  localparam logic [7:0]  RST_LANE_DRV     = 8'h00;
  localparam logic [7:0]  RST_LINK_CFG     = 8'h7d;
  localparam logic [7:0]  LANE_DRV_MASK    = 8'h77;
  localparam logic [9:0]  IDLE_PATTERN     = 10'h155;
  localparam int          PAT_W            = 10;

  // lane driver fields
  localparam int          SWING_LSB        = 4;
  localparam int          DEEMPH_LSB       = 0;
  // link config fields
  localparam int          SCR_BIT          = 7;
  localparam int          FPM_LSB          = 2;
  localparam int          LANES_BIT        = 1;
  localparam int          EN_BIT           = 0;

  typedef struct packed {
    logic       scrambler_on;
    logic [4:0] frames_per_multiframe_minus_one;
    logic       lanes_per_channel_minus_one;
  } sltc_framer_cfg_s;

  typedef struct packed {
    logic [2:0] driver_swing_sel;
    logic [2:0] deemphasis_sel;
  } sltc_driver_cfg_s;

endpackage

// file: sltc_idle_gen.sv
// Purpose: alternating idle pattern source for a disabled link
// Assumes: one parallel word per clock towards the serialiser
// Notes:   even word width keeps the 0101 phase continuous
`timescale 1ns/1ps
module sltc_idle_gen
  import sltc_pkg::*;
(
  input  wire logic              clk,     // register clock
  input  wire logic              nrst,    // async reset, active low
  output logic     [PAT_W-1:0]   pattern  // repeating 0101 word
);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pattern <= '0;
    end else begin
      pattern <= IDLE_PATTERN;
    end
  end

endmodule // sltc_idle_gen

// file: sltc_top.sv
// Purpose: transmit link configuration registers and lane word select
// Assumes: serial port gives one-cycle wr_stb/rd_stb with addr and wdata
// Notes:   framer settings shadowed while the link is disabled
//          lane word and link_enable switch on the same clock edge
//          unmapped addresses ignore writes and read back as zero
// Notes on behaviour
// - bit 7 of link config enables scrambling; resets to off.
// - bits 6:2 hold frames per multiframe minus one; reset 11111 gives 32.
// - bit 1 is lanes per channel minus one; reset is single lane.
// - bit 0 is link enable; resets to 1, writing 0 disables.
// - enabled link sends framer data normally.
// - disabled link repeats 0101010101 on every lane.
// - bits 6:4 pick one of eight driver swings, 0.580 V to 1.240 V.
// - bits 2:0 pick one of eight de-emphasis levels, none to strongest.
`timescale 1ns/1ps
module sltc_top
  import sltc_pkg::*;
#(
  parameter int LANE_W = PAT_W
)(
  input  wire logic              clk,           // 50 MHz register clock
  input  wire logic              nrst,          // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,          // register address
  input  wire logic [DATA_W-1:0] wdata,         // write data
  input  wire logic              wr_stb,        // write strobe, one cycle
  input  wire logic              rd_stb,        // read strobe, one cycle
  input  wire logic [LANE_W-1:0] framer_word,   // framed word from the framer
  output logic      [DATA_W-1:0] rdata,         // read data
  output logic                   rvalid,        // read data valid pulse
  output logic                   link_enable,   // link running
  output sltc_framer_cfg_s       framer_cfg,    // settings used by the framer
  output sltc_driver_cfg_s       driver_cfg,    // lane driver analog codes
  output logic      [LANE_W-1:0] lane_word      // word to the serialiser
);

  // ----------------------------------------------------------------
  // register and next-value signals
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] lane_drv_r;
  logic [DATA_W-1:0] link_cfg_r;
  logic [PAT_W-1:0]  idle_word;
  logic [DATA_W-1:0] lane_drv_nxt;
  logic [DATA_W-1:0] link_cfg_nxt;

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam int               FPM_W      = SCR_BIT - FPM_LSB;
  localparam int               CODE_W     = $bits(sltc_driver_cfg_s) / 2;
  localparam sltc_framer_cfg_s FRAMER_RST = RST_LINK_CFG[SCR_BIT:LANES_BIT];
  localparam logic             EN_RST     = RST_LINK_CFG[EN_BIT];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // strobe target match
  function automatic logic hits(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    return a == target;
  endfunction

  // framer view of the link config byte
  function automatic sltc_framer_cfg_s framer_fields(input logic [DATA_W-1:0] v);
    sltc_framer_cfg_s f;
    f.scrambler_on                    = v[SCR_BIT];
    f.frames_per_multiframe_minus_one = v[FPM_LSB +: FPM_W];
    f.lanes_per_channel_minus_one     = v[LANES_BIT];
    return f;
  endfunction

  // analog codes of the lane driver byte
  function automatic sltc_driver_cfg_s driver_fields(input logic [DATA_W-1:0] v);
    sltc_driver_cfg_s c;
    c.driver_swing_sel = v[SWING_LSB +: CODE_W];
    c.deemphasis_sel   = v[DEEMPH_LSB +: CODE_W];
    return c;
  endfunction

  // link enable bit of the link config byte
  function automatic logic link_on(input logic [DATA_W-1:0] v);
    return v[EN_BIT];
  endfunction

  // read-back byte, zero for unmapped addresses
  function automatic logic [DATA_W-1:0] readback(
    input logic              hit_drv,
    input logic              hit_link,
    input logic [DATA_W-1:0] drv,
    input logic [DATA_W-1:0] link
  );
    return hit_drv ? drv : (hit_link ? link : '0);
  endfunction

  // framed data while running, idle pattern while stopped
  function automatic logic [LANE_W-1:0] lane_pick(
    input logic              en,
    input logic [LANE_W-1:0] data,
    input logic [LANE_W-1:0] idle
  );
    return en ? data : idle;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire sel_drv  = hits(addr, ADDR_LANE_DRV);
  wire sel_link = hits(addr, ADDR_LINK_CFG);
  wire wr_drv   = wr_stb && sel_drv;
  wire wr_link  = wr_stb && sel_link;

  wire [DATA_W-1:0] rd_mux = readback(sel_drv, sel_link, lane_drv_r, link_cfg_r);

  // reserved driver bits held at zero whatever software writes
  wire [DATA_W-1:0] drv_wdata = wdata & LANE_DRV_MASK;

  // each register keeps its value unless its own strobe hits
  assign lane_drv_nxt = wr_drv  ? drv_wdata : lane_drv_r;
  assign link_cfg_nxt = wr_link ? wdata     : link_cfg_r;

  wire sltc_framer_cfg_s cfg_live    = framer_fields(link_cfg_r);
  wire sltc_driver_cfg_s driver_live = driver_fields(lane_drv_r);
  wire                   en_live     = link_on(link_cfg_r);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_drv_r <= RST_LANE_DRV;
    end else begin
      lane_drv_r <= lane_drv_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_cfg_r <= RST_LINK_CFG;
    end else begin
      link_cfg_r <= link_cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // rvalid pulses once per strobe; rdata holds until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_stb;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // framer shadow and outputs
  // ----------------------------------------------------------------
  // shadow follows the live fields only while the link is stopped, so a
  // running framer never sees a half-written configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      framer_cfg <= FRAMER_RST;
    end else if (!en_live) begin
      framer_cfg <= cfg_live;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_enable <= EN_RST;
    end else begin
      link_enable <= en_live;
    end
  end

  // driver codes reach the pads one cycle after the register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      driver_cfg <= '0;
    end else begin
      driver_cfg <= driver_live;
    end
  end

  sltc_idle_gen u_idle (
    .clk     (clk),
    .nrst    (nrst),
    .pattern (idle_word)
  );

  // ----------------------------------------------------------------
  // lane word select
  // ----------------------------------------------------------------
  // select follows the register, not link_enable, so lane_word and
  // link_enable change on the same edge
  wire [LANE_W-1:0] idle_fit = LANE_W'(idle_word);
  wire [LANE_W-1:0] lane_nxt = lane_pick(en_live, framer_word, idle_fit);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_word <= '0;
    end else begin
      lane_word <= lane_nxt;
    end
  end

endmodule // sltc_top

// file: sltc_framer_model.sv
// Purpose: framer stand-in, a new word every cycle
// Assumes: inputs change at the falling edge
// Notes:   johnson count never equals the idle word
`timescale 1ns/1ps
module sltc_framer_model #(parameter int W = 10)(
  input  wire logic         clk,  // clock
  output logic      [W-1:0] word  // framed word
);
  initial word = '0;
  always @(negedge clk) word <= {word[W-2:0], ~word[W-1]};
endmodule // sltc_framer_model

// file: sltc_monitor.sv
// Purpose: port assertions for sltc_top
// Assumes: one clock, nrst async active low
// Notes:   bound to every sltc_top
`timescale 1ns/1ps
module sltc_monitor
  import sltc_pkg::*;
#(parameter int LANE_W = PAT_W)(
  input wire logic              clk, nrst, wr_stb, rd_stb, rvalid, link_enable, // controls
  input wire logic [7:0]        addr, wdata, rdata,                             // bus
  input wire logic [LANE_W-1:0] framer_word, lane_word,                         // lane words
  input wire sltc_framer_cfg_s  framer_cfg,                                     // framer settings
  input wire sltc_driver_cfg_s  driver_cfg                                      // driver codes
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_link; wr_stb && addr == ADDR_LINK_CFG; endsequence
  sequence s_wr_drv; wr_stb && addr == ADDR_LANE_DRV; endsequence
  chk_drv_read_gaps:
    assert property (rd_stb && addr == ADDR_LANE_DRV |=> rvalid && !rdata[7] && !rdata[3]) else $error("drv read");
  chk_link_read_en:
    assert property (rd_stb && addr == ADDR_LINK_CFG |=> rvalid && rdata[0] == link_enable) else $error("link read");
  chk_enable_follows:
    assert property (s_wr_link |-> ##2 link_enable == $past(wdata[0], 2)) else $error("enable");
  chk_drv_follows:
    assert property (s_wr_drv |-> ##2 driver_cfg == {$past(wdata[6:4], 2), $past(wdata[2:0], 2)}) else $error("drv");
  chk_lane_data:
    assert property (link_enable && $past(nrst) |-> lane_word == $past(framer_word)) else $error("lane data");
  chk_lane_idle:
    assert property (!link_enable |-> lane_word == IDLE_PATTERN) else $error("lane idle");
  chk_framer_frozen:
    assert property (link_enable |-> $stable(framer_cfg)) else $error("framer moved");
  chk_framer_load:
    assert property (s_wr_link ##2 !link_enable |-> framer_cfg == $past(wdata[7:1], 2)) else $error("framer load");
endmodule // sltc_monitor
bind sltc_top sltc_monitor #(.LANE_W(LANE_W)) u_mon (.clk, .nrst, .wr_stb, .rd_stb, .rvalid, .link_enable, .addr,
  .wdata, .rdata, .framer_word, .lane_word, .framer_cfg, .driver_cfg);

// file: testbench.sv
// Purpose: self-checking bench for sltc_top
// Assumes: 50 MHz clock, xorshift stimulus
// Notes:   software keeps the legal field ranges
`timescale 1ns/1ps
module testbench;
  import sltc_pkg::*;
  logic             clk = 1'h0, nrst = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0, rvalid, link_enable;
  logic [7:0]       addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [9:0]       framer_word, lane_word;
  logic [31:0]      seed = 32'h76de, r;
  sltc_framer_cfg_s framer_cfg;
  sltc_driver_cfg_s driver_cfg;
  int               errors = 0, checks = 0;
  initial forever #10 clk = ~clk;
  sltc_framer_model u_frm (.clk(clk), .word(framer_word));
  sltc_top u_dut (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .framer_word, .rdata, .rvalid, .link_enable,
    .framer_cfg, .driver_cfg, .lane_word);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // frames-per-multiframe minus one inside the legal span for the lane count
  function automatic logic [4:0] fpm_code(logic dual, logic [31:0] v);
    return dual ? 5'(16 + v % 16) : 5'(8 + v % 24);
  endfunction
  task automatic chk(logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, v);
    @(negedge clk);
    {wr_stb, addr, wdata} = {1'h1, a, v};
    @(negedge clk);
    wr_stb = 1'h0;
  endtask
  task automatic rd(logic [7:0] a, e);
    @(negedge clk);
    {rd_stb, addr} = {1'h1, a};
    @(negedge clk);
    rd_stb = 1'h0;
    chk({rvalid, rdata}, {1'h1, e});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'h1;
    chk({link_enable, framer_cfg, driver_cfg}, {1'h1, 7'h3e, 6'h00});
    rd(ADDR_LINK_CFG, RST_LINK_CFG);
    rd(ADDR_LANE_DRV, RST_LANE_DRV);
    wr(8'h61, 8'hff);
    rd(8'h61, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = {1'h0, 3'(i), 1'h0, 3'(7 - i)};
      wr(ADDR_LANE_DRV, d);
      @(negedge clk);
      chk(driver_cfg, {d[6:4], d[2:0]});
      rd(ADDR_LANE_DRV, d);
    end
    wr(ADDR_LINK_CFG, 8'h7c);
    @(negedge clk);
    chk({link_enable, lane_word}, {1'h0, IDLE_PATTERN});
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      d = {r[7], fpm_code(r[1], r), r[1], 1'h0};
      wr(ADDR_LINK_CFG, d);
      @(negedge clk);
      chk(framer_cfg, d[7:1]);
      rd(ADDR_LINK_CFG, d);
      wr(ADDR_LINK_CFG, d | 8'h01);
      repeat (2) @(negedge clk);
      chk({link_enable, framer_cfg, lane_word == IDLE_PATTERN}, {1'h1, d[7:1], 1'h0});
      wr(ADDR_LINK_CFG, d);
      @(negedge clk);
      chk(lane_word, IDLE_PATTERN);
    end
    tally_and_finish();
  end
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
endmodule // testbench
